// [rtl/output_driver_power_protection.sv]
/*
  register core and protection logic for the headphone pair and the
  mono class-d speaker: power, gain, mute, common mode, lineout mode,
  short-circuit response and status flags.
  assumes: the serial control port decodes page, offset and strobes on
  mclk; fault detector inputs are asynchronous levels from the analog.
*/
// Notes on behaviour
// - writing 11 into d2..d1 of power mode puts headphones in lineout mode
// - d4..d3 of headphone control pick one of four common-mode levels
// - headphone control d7 powers left stage, d6 powers right stage
// - left gain register: gain code d6..d3, mute d2
// - right gain register: gain code d6..d3, mute d2
// - headphone short protection always on; d1 picks limit or shutdown
// - a short on either headphone sets read-only flag d0
// - in shutdown mode a short clears the affected power bit at once
// - setting a power bit again re-arms; a persisting short trips again
// - pin reset returns every register to default, software reset all but the ramp and sync flops
// - speaker control d7 powers the class-d stage
// - speaker gain register: gain code d4..d3, mute d2
// - speaker overcurrent always shuts down and sets read-only flag d0
// - setting speaker d7 again re-arms; a persisting fault trips again
// - overtemperature stops speaker switching, flag d1 of page-zero status
// - any power change runs a soft-start; all stages may start together
`timescale 1ns/10ps
`default_nettype none
`include "output_driver_consts.svh"

module output_driver_power_protection
(
  // clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       sw_reset,
  // control port register access
  input  wire logic       reg_page,
  input  wire logic [6:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  output var  logic       reg_rd_valid,
  // analog fault detectors
  input  wire logic       left_short,
  input  wire logic       right_short,
  input  wire logic       spk_overcurrent,
  input  wire logic       overtemp,
  // stage power and soft-start
  output var  logic       left_headphone_out_pwr,
  output var  logic       right_headphone_out_pwr,
  output var  logic       speaker_out_pwr,
  output var  logic [2:0] stage_ramping,
  output var  logic [2:0] stage_at_full,
  output var  logic       speaker_switch_en,
  // headphone settings
  output var  logic [3:0] left_gain,
  output var  logic       left_mute,
  output var  logic [3:0] right_gain,
  output var  logic       right_mute,
  output var  logic [1:0] common_mode_sel,
  output var  logic       lineout_mode,
  output var  logic       left_current_limit,
  output var  logic       right_current_limit,
  // speaker settings
  output var  logic [1:0] spk_gain,
  output var  logic       spk_mute
);

  // ****************************************************
  // declarations
  // ****************************************************
  localparam int LEFT  = int'(output_driver_pkg::STAGE_LEFT);
  localparam int RIGHT = int'(output_driver_pkg::STAGE_RIGHT);
  localparam int SPK   = int'(output_driver_pkg::STAGE_SPK);

  output_driver_pkg::reg_byte_t left_gain_reg;
  output_driver_pkg::reg_byte_t right_gain_reg;
  output_driver_pkg::reg_byte_t spk_gain_reg;
  output_driver_pkg::reg_byte_t power_mode_reg;
  output_driver_pkg::reg_byte_t rdata_next;

  logic       left_pwr_reg;
  logic       right_pwr_reg;
  logic       spk_pwr_reg;
  logic [1:0] cm_reg;
  logic       sc_mode_reg;
  logic       hp_flag_reg;
  logic       spk_flag_reg;
  logic [3:0] fault_raw;
  logic [3:0] fault_s;
  logic       master_rst;
  logic       sel_page0;
  logic       sel_page1;
  logic       wr_hp_ctrl;
  logic       wr_spk_ctrl;
  logic       wr_left_gain;
  logic       wr_right_gain;
  logic       wr_spk_gain;
  logic       wr_power_mode;
  logic       rd_hp_ctrl;
  logic       rd_spk_ctrl;
  logic       left_fault;
  logic       right_fault;
  logic       spk_fault;
  logic       left_trip;
  logic       right_trip;
  logic       hp_flag_next;
  logic       spk_flag_next;
  logic       ot_s;

  stage_if stages ();

  // ****************************************************
  // fault input synchronisers
  // ****************************************************
  assign fault_raw = {overtemp, spk_overcurrent, right_short, left_short};

  fault_sync u_sync
  (
    .mclk     (mclk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (fault_raw),
    .sync_out (fault_s)
  );

  assign ot_s = fault_s[3];

  // ****************************************************
  // address and strobe decode
  // ****************************************************
  assign master_rst    = rst || sw_reset;
  assign sel_page0     = (reg_page == `PAGE_STATUS);
  assign sel_page1     = (reg_page == `PAGE_ANALOG);
  assign wr_hp_ctrl    = reg_wr && sel_page1 && (reg_addr == `HP_DRIVER_CTRL_OFS);
  assign wr_spk_ctrl   = reg_wr && sel_page1 && (reg_addr == `SPK_DRIVER_CTRL_OFS);
  assign wr_left_gain  = reg_wr && sel_page1 && (reg_addr == `LEFT_HP_GAIN_OFS);
  assign wr_right_gain = reg_wr && sel_page1 && (reg_addr == `RIGHT_HP_GAIN_OFS);
  assign wr_spk_gain   = reg_wr && sel_page1 && (reg_addr == `SPK_GAIN_OFS);
  assign wr_power_mode = reg_wr && sel_page1 && (reg_addr == `HP_POWER_MODE_OFS);
  assign rd_hp_ctrl    = reg_rd && sel_page1 && (reg_addr == `HP_DRIVER_CTRL_OFS);
  assign rd_spk_ctrl   = reg_rd && sel_page1 && (reg_addr == `SPK_DRIVER_CTRL_OFS);

  // ****************************************************
  // fault qualification, only a powered stage can fault
  // ****************************************************
  assign left_fault  = fault_s[0] && left_pwr_reg;
  assign right_fault = fault_s[1] && right_pwr_reg;
  assign spk_fault   = fault_s[2] && spk_pwr_reg;
  assign left_trip   = left_fault && sc_mode_reg;
  assign right_trip  = right_fault && sc_mode_reg;

  // sticky flags clear on read, a new fault wins over the clear
  assign hp_flag_next  = (left_fault || right_fault) ||
                         (hp_flag_reg && !rd_hp_ctrl);
  assign spk_flag_next = spk_fault ||
                         (spk_flag_reg && !rd_spk_ctrl);

  // ****************************************************
  // headphone power bits, a write re-arms, a trip clears
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (master_rst)
      left_pwr_reg <= 1'b0;
    else if (clk_en && wr_hp_ctrl)
      left_pwr_reg <= reg_wdata[`PWR_LEFT_BIT];
    else if (clk_en && left_trip)
      left_pwr_reg <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (master_rst)
      right_pwr_reg <= 1'b0;
    else if (clk_en && wr_hp_ctrl)
      right_pwr_reg <= reg_wdata[`PWR_RIGHT_BIT];
    else if (clk_en && right_trip)
      right_pwr_reg <= 1'b0;
  end

  // ****************************************************
  // speaker power bit, overcurrent always shuts down
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (master_rst)
      spk_pwr_reg <= 1'b0;
    else if (clk_en && wr_spk_ctrl)
      spk_pwr_reg <= reg_wdata[`PWR_SPK_BIT];
    else if (clk_en && spk_fault)
      spk_pwr_reg <= 1'b0;
  end

  // ****************************************************
  // headphone control fields and status flags
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (master_rst)
    begin
      cm_reg       <= 2'h0;
      sc_mode_reg  <= 1'b0;
      hp_flag_reg  <= 1'b0;
      spk_flag_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_hp_ctrl)
      begin
        cm_reg      <= reg_wdata[`CM_MSB:`CM_LSB];
        sc_mode_reg <= reg_wdata[`SC_MODE_BIT];
      end
      hp_flag_reg  <= hp_flag_next;
      spk_flag_reg <= spk_flag_next;
    end
  end

  // ****************************************************
  // gain and power mode registers, stored as written
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (master_rst)
    begin
      left_gain_reg  <= `REG_RESET;
      right_gain_reg <= `REG_RESET;
      spk_gain_reg   <= `REG_RESET;
      power_mode_reg <= `REG_RESET;
    end
    else if (clk_en)
    begin
      if (wr_left_gain)
        left_gain_reg <= reg_wdata;
      if (wr_right_gain)
        right_gain_reg <= reg_wdata;
      if (wr_spk_gain)
        spk_gain_reg <= reg_wdata;
      if (wr_power_mode)
        power_mode_reg <= reg_wdata;
    end
  end

  // ****************************************************
  // read mux, unmapped offsets read zero
  // ****************************************************
  always_comb
  begin
    rdata_next = 8'h00;
    if (sel_page0 && (reg_addr == `OVERTEMP_STATUS_OFS))
      rdata_next[`OVERTEMP_BIT] = ot_s;
    else if (sel_page1)
    begin
      unique case (reg_addr)
        `HP_DRIVER_CTRL_OFS:
        begin
          rdata_next[`PWR_LEFT_BIT]      = left_pwr_reg;
          rdata_next[`PWR_RIGHT_BIT]     = right_pwr_reg;
          rdata_next[`CM_MSB:`CM_LSB]    = cm_reg;
          rdata_next[`SC_MODE_BIT]       = sc_mode_reg;
          rdata_next[`FAULT_FLAG_BIT]    = hp_flag_reg;
        end
        `SPK_DRIVER_CTRL_OFS:
        begin
          rdata_next[`PWR_SPK_BIT]       = spk_pwr_reg;
          rdata_next[`FAULT_FLAG_BIT]    = spk_flag_reg;
        end
        `LEFT_HP_GAIN_OFS:  rdata_next = left_gain_reg;
        `RIGHT_HP_GAIN_OFS: rdata_next = right_gain_reg;
        `SPK_GAIN_OFS:      rdata_next = spk_gain_reg;
        `HP_POWER_MODE_OFS: rdata_next = power_mode_reg;
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  // read data and its valid strobe, one cycle after the request
  always_ff @(posedge mclk)
  begin
    if (master_rst)
    begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rd_valid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rdata_next;
    end
  end

  // ****************************************************
  // soft-start ramps
  // ****************************************************
  assign stages.power_req[LEFT]  = left_pwr_reg;
  assign stages.power_req[RIGHT] = right_pwr_reg;
  assign stages.power_req[SPK]   = spk_pwr_reg;

  stage_ramp u_ramp
  (
    .mclk   (mclk),
    .rst    (rst),
    .clk_en (clk_en),
    .stages (stages)
  );

  assign stage_ramping = stages.ramping;
  assign stage_at_full = stages.at_full;

  // ****************************************************
  // drive towards the analog stages
  // ****************************************************
  assign left_headphone_out_pwr  = left_pwr_reg;
  assign right_headphone_out_pwr = right_pwr_reg;
  assign speaker_out_pwr         = spk_pwr_reg;
  assign left_gain   = left_gain_reg[`HP_GAIN_MSB:`HP_GAIN_LSB];
  assign left_mute   = left_gain_reg[`MUTE_BIT];
  assign right_gain  = right_gain_reg[`HP_GAIN_MSB:`HP_GAIN_LSB];
  assign right_mute  = right_gain_reg[`MUTE_BIT];
  assign spk_gain    = spk_gain_reg[`SPK_GAIN_MSB:`SPK_GAIN_LSB];
  assign spk_mute    = spk_gain_reg[`MUTE_BIT];
  assign common_mode_sel = cm_reg;

  // registered drive controls
  always_ff @(posedge mclk)
  begin
    if (master_rst)
    begin
      lineout_mode        <= 1'b0;
      left_current_limit  <= 1'b0;
      right_current_limit <= 1'b0;
      speaker_switch_en   <= 1'b0;
    end
    else if (clk_en)
    begin
      lineout_mode        <= (power_mode_reg[`LINEOUT_MSB:`LINEOUT_LSB] == `LINEOUT_CODE);
      left_current_limit  <= left_fault && !sc_mode_reg;
      right_current_limit <= right_fault && !sc_mode_reg;
      speaker_switch_en   <= stages.at_full[SPK] && !ot_s;
    end
  end

endmodule : output_driver_power_protection

`default_nettype wire

// [pkg/output_driver_consts.svh]
/*
  offsets, field positions, reset values and timing counts of the
  output driver power and protection block.
  assumes: included by bare name from design files.
*/
`ifndef OUTPUT_DRIVER_CONSTS_SVH
`define OUTPUT_DRIVER_CONSTS_SVH

// ****************************************************
// register pages and offsets
// ****************************************************
`define PAGE_STATUS         1'h0
`define PAGE_ANALOG         1'h1
`define OVERTEMP_STATUS_OFS 7'h03
`define HP_DRIVER_CTRL_OFS  7'h1f
`define SPK_DRIVER_CTRL_OFS 7'h20
`define LEFT_HP_GAIN_OFS    7'h28
`define RIGHT_HP_GAIN_OFS   7'h29
`define SPK_GAIN_OFS        7'h2a
`define HP_POWER_MODE_OFS   7'h2c

// ****************************************************
// field positions
// ****************************************************
`define PWR_LEFT_BIT        7
`define PWR_RIGHT_BIT       6
`define PWR_SPK_BIT         7
`define CM_MSB              4
`define CM_LSB              3
`define SC_MODE_BIT         1
`define FAULT_FLAG_BIT      0
`define OVERTEMP_BIT        1
`define HP_GAIN_MSB         6
`define HP_GAIN_LSB         3
`define SPK_GAIN_MSB        4
`define SPK_GAIN_LSB        3
`define MUTE_BIT            2
`define LINEOUT_MSB         2
`define LINEOUT_LSB         1
`define LINEOUT_CODE        2'h3

// ****************************************************
// reset values and timing
// ****************************************************
`define REG_RESET           8'h00
`define MCLK_PERIOD_NS      4
`define SOFT_START_NS       1000
`define SOFT_START_CYCLES   ((`SOFT_START_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// [pkg/output_driver_pkg.sv]
/*
  types shared by the output driver block.
  assumes: constants come from output_driver_consts.svh.
*/
`default_nettype none

package output_driver_pkg;

  // one byte of the register file
  typedef logic [7:0] reg_byte_t;

  // output stage index
  typedef enum logic [1:0]
  {
    STAGE_LEFT  = 2'b00,
    STAGE_RIGHT = 2'b01,
    STAGE_SPK   = 2'b10
  } stage_t;

  // soft-start level counter
  typedef logic [7:0] ramp_cnt_t;

endpackage : output_driver_pkg

`default_nettype wire

// [pkg/stage_if.sv]
/*
  carrier between the register core and the soft-start ramps.
  assumes: one bit per stage, indexed by output_driver_pkg::stage_t.
*/
`timescale 1ns/10ps
`default_nettype none

interface stage_if;
  logic [2:0] power_req;  // stage power bits
  logic [2:0] at_full;    // ramp finished up
  logic [2:0] ramping;    // ramp in progress

  modport ctrl
  (
    output power_req,
    input  at_full,
    input  ramping
  );

  modport ramp
  (
    input  power_req,
    output at_full,
    output ramping
  );
endinterface : stage_if

`default_nettype wire

// [rtl/fault_sync.sv]
/*
  two-flop synchronisers for the analog fault detector levels.
  assumes: inputs are asynchronous levels; nothing reads stage one.
*/
`timescale 1ns/10ps
`default_nettype none

module fault_sync
(
  // clock and control
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // levels
  input  wire logic [3:0] async_in,
  output var  logic [3:0] sync_out
);

  logic [3:0] meta_reg;

  // ****************************************************
  // one synchroniser per fault bit
  // ****************************************************
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_bit
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else if (clk_en)
        begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule : fault_sync

`default_nettype wire

// [rtl/stage_ramp.sv]
/*
  soft-start ramps for the three output stages.
  assumes: power requests come from the register core on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "output_driver_consts.svh"

module stage_ramp
(
  // clock and control
  input  wire logic   mclk,
  input  wire logic   rst,
  input  wire logic   clk_en,
  // stage carrier
  stage_if.ramp       stages
);

  localparam output_driver_pkg::ramp_cnt_t RAMP_TOP =
    output_driver_pkg::ramp_cnt_t'(`SOFT_START_CYCLES);

  // ****************************************************
  // per stage level counter, up when powered, down when not
  // ****************************************************
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_stage
      output_driver_pkg::ramp_cnt_t lvl_reg;
      logic                         up_w;
      logic                         down_w;

      assign up_w   = stages.power_req[i] && (lvl_reg != RAMP_TOP);
      assign down_w = !stages.power_req[i] && (lvl_reg != '0);
      assign stages.ramping[i] = up_w || down_w;
      assign stages.at_full[i] = stages.power_req[i] && (lvl_reg == RAMP_TOP);

      always_ff @(posedge mclk)
      begin
        if (rst)
          lvl_reg <= '0;
        else if (clk_en && up_w)
          lvl_reg <= lvl_reg + 8'h01;
        else if (clk_en && down_w)
          lvl_reg <= lvl_reg - 8'h01;
      end
    end
  endgenerate

endmodule : stage_ramp

`default_nettype wire

// [sim/output_driver_properties.sv]
/*
  concurrent checks of the output driver block, seeing its ports only.
  assumes: bound to the top module; one clock mclk, reset rst.
*/
`timescale 1ns/10ps
`default_nettype none
`include "output_driver_consts.svh"

module output_driver_properties
(
  // clock and control
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic       sw_reset,
  // register port
  input wire logic       reg_page,
  input wire logic [6:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rd_valid,
  // fault detectors
  input wire logic       left_short,
  input wire logic       right_short,
  input wire logic       spk_overcurrent,
  input wire logic       overtemp,
  // stage power
  input wire logic       left_headphone_out_pwr,
  input wire logic       right_headphone_out_pwr,
  input wire logic       speaker_out_pwr,
  input wire logic [2:0] stage_ramping,
  input wire logic [2:0] stage_at_full,
  input wire logic       speaker_switch_en,
  // settings
  input wire logic [3:0] left_gain,
  input wire logic       left_mute,
  input wire logic [3:0] right_gain,
  input wire logic       right_mute,
  input wire logic [1:0] common_mode_sel,
  input wire logic       lineout_mode,
  input wire logic       left_current_limit,
  input wire logic       right_current_limit,
  input wire logic [1:0] spk_gain,
  input wire logic       spk_mute
);
  // ****************************************************
  // properties
  // ****************************************************
  // all checks on mclk, quiet during rst
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // taken write on the analog page
  wire logic wr1 = reg_wr && clk_en && !sw_reset && reg_page == `PAGE_ANALOG;

  a_left_gain_store: assert property (wr1 && reg_addr == `LEFT_HP_GAIN_OFS |=>
    left_gain == $past(reg_wdata[6:3]) && left_mute == $past(reg_wdata[2])) else $error("left gain not stored");
  a_right_gain_store: assert property (wr1 && reg_addr == `RIGHT_HP_GAIN_OFS |=>
    right_gain == $past(reg_wdata[6:3]) && right_mute == $past(reg_wdata[2])) else $error("right gain not stored");
  a_spk_gain_store: assert property (wr1 && reg_addr == `SPK_GAIN_OFS |=>
    spk_gain == $past(reg_wdata[4:3]) && spk_mute == $past(reg_wdata[2])) else $error("speaker gain not stored");
  a_cm_store: assert property (wr1 && reg_addr == `HP_DRIVER_CTRL_OFS |=>
    common_mode_sel == $past(reg_wdata[4:3])) else $error("common mode not stored");
  a_lineout_set: assert property (wr1 && reg_addr == `HP_POWER_MODE_OFS && reg_wdata[2:1] == 2'h3
    |=> ##1 lineout_mode) else $error("lineout mode not entered");
  a_spk_trip: assert property ((spk_overcurrent && clk_en && !reg_wr)[*5] |-> !speaker_out_pwr)
    else $error("speaker not shut down");
  a_limit_needs_pwr: assert property (left_current_limit |-> $past(left_headphone_out_pwr))
    else $error("current limit on unpowered stage");
  a_full_needs_pwr: assert property (stage_at_full[2] |-> speaker_out_pwr)
    else $error("speaker full while unpowered");
  a_switch_gate: assert property (speaker_switch_en |-> $past(stage_at_full[2]))
    else $error("speaker switching before full");
  a_overtemp_stop: assert property ((overtemp && clk_en)[*4] |-> !speaker_switch_en)
    else $error("speaker switching while overheated");
  a_sw_reset_clear: assert property (sw_reset && clk_en |=> reg_rdata == 8'h00 && left_gain == 4'h0
    && !speaker_out_pwr) else $error("software reset left state");
endmodule : output_driver_properties

`default_nettype wire

// [sim/output_driver_power_protection_tb.sv]
/*
  self-checking bench of the output driver block.
  assumes: design files compiled first; 250 MHz mclk.
*/
`timescale 1ns/10ps
`default_nettype none

module output_driver_power_protection_tb;
  logic       mclk = 1'b0, rst = 1'b1, clk_en = 1'b1, sw_reset = 1'b0;
  logic       reg_page = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_rd_valid;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic       left_short = 1'b0, right_short = 1'b0, spk_overcurrent = 1'b0, overtemp = 1'b0;
  logic       left_headphone_out_pwr, right_headphone_out_pwr, speaker_out_pwr, speaker_switch_en;
  logic [2:0] stage_ramping, stage_at_full;
  logic [3:0] left_gain, right_gain;
  logic       left_mute, right_mute, lineout_mode, left_current_limit, right_current_limit, spk_mute;
  logic [1:0] common_mode_sel, spk_gain;
  int         bad_count = 0, n_tests = 0, cyc_count = 0;
  wire logic [2:0] pwr = {speaker_out_pwr, right_headphone_out_pwr, left_headphone_out_pwr};
  wire logic [1:0] lim = {right_current_limit, left_current_limit};

  // 4 ns clock
  always #2 mclk = ~mclk;

  output_driver_power_protection dut
  (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .sw_reset(sw_reset), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .left_short(left_short),
    .right_short(right_short), .spk_overcurrent(spk_overcurrent), .overtemp(overtemp),
    .left_headphone_out_pwr(left_headphone_out_pwr), .right_headphone_out_pwr(right_headphone_out_pwr),
    .speaker_out_pwr(speaker_out_pwr), .stage_ramping(stage_ramping), .stage_at_full(stage_at_full),
    .speaker_switch_en(speaker_switch_en), .left_gain(left_gain), .left_mute(left_mute),
    .right_gain(right_gain), .right_mute(right_mute), .common_mode_sel(common_mode_sel),
    .lineout_mode(lineout_mode), .left_current_limit(left_current_limit),
    .right_current_limit(right_current_limit), .spk_gain(spk_gain), .spk_mute(spk_mute)
  );

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic complete_run;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic wr(input logic p, input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_page = p;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask : wr

  task automatic rd(input logic p, input logic [6:0] a);
    @(negedge mclk);
    reg_page = p;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
  endtask : rd

  task automatic rd_chk(input logic p, input logic [6:0] a, input logic [7:0] exp);
    rd(p, a);
    chk("rd_valid", 8'(reg_rd_valid), 8'h01);
    chk($sformatf("rdata %h", a), reg_rdata, exp);
  endtask : rd_chk

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset;
    logic [6:0] ofs [7] = '{7'h03, 7'h1f, 7'h20, 7'h28, 7'h29, 7'h2a, 7'h2c};
    for (int i = 0; i < 7; i++)
      rd_chk(i != 0, ofs[i], 8'h00);
    rd_chk(1'h1, 7'h7f, 8'h00);
    chk("pwr", 8'(pwr), 8'h00);
  endtask : t_reset

  task automatic t_settings;
    wr(1'h1, 7'h28, 8'h7c);
    chk("lg", {3'h0, left_gain, left_mute}, 8'h1f);
    wr(1'h1, 7'h29, 8'h2b);
    chk("rg", {3'h0, right_gain, right_mute}, 8'h0a);
    wr(1'h1, 7'h2a, 8'h1c);
    chk("sg", {5'h0, spk_gain, spk_mute}, 8'h07);
    rd_chk(1'h1, 7'h29, 8'h2b);
    rd_chk(1'h1, 7'h2a, 8'h1c);
    wr(1'h1, 7'h2c, 8'h06);
    cyc(1);
    chk("lo", 8'(lineout_mode), 8'h01);
    wr(1'h1, 7'h2c, 8'h04);
    cyc(1);
    chk("lo", 8'(lineout_mode), 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(1'h1, 7'h1f, 8'(i << 3));
      chk("cm", 8'(common_mode_sel), 8'(i));
    end
    wr(1'h0, 7'h03, 8'hff);
    rd_chk(1'h0, 7'h03, 8'h00);
    wr(1'h1, 7'h7f, 8'hff);
    rd_chk(1'h1, 7'h7f, 8'h00);
    clk_en = 1'b0;
    wr(1'h1, 7'h28, 8'h00);
    clk_en = 1'b1;
    chk("lg", {3'h0, left_gain, left_mute}, 8'h1f);
  endtask : t_settings

  task automatic t_hp_short;
    wr(1'h1, 7'h1f, 8'hc0);
    chk("pwr", 8'(pwr), 8'h03);
    left_short = 1'b1;
    right_short = 1'b1;
    cyc(5);
    chk("lim", 8'(lim), 8'h03);
    chk("pwr", 8'(pwr), 8'h03);
    rd_chk(1'h1, 7'h1f, 8'hc1);
    left_short = 1'b0;
    right_short = 1'b0;
    cyc(4);
    rd(1'h1, 7'h1f);
    wr(1'h1, 7'h1f, 8'hc2);
    right_short = 1'b1;
    cyc(5);
    chk("pwr", 8'(pwr), 8'h01);
    rd_chk(1'h1, 7'h1f, 8'h83);
    // re-arm once into a live short, trips again
    wr(1'h1, 7'h1f, 8'hc2);
    cyc(3);
    chk("pwr", 8'(pwr), 8'h01);
    right_short = 1'b0;
    cyc(4);
    rd(1'h1, 7'h1f);
    wr(1'h1, 7'h1f, 8'hc2);
    cyc(3);
    chk("pwr", 8'(pwr), 8'h03);
    rd_chk(1'h1, 7'h1f, 8'hc2);
  endtask : t_hp_short

  task automatic t_speaker;
    wr(1'h1, 7'h20, 8'h80);
    chk("ramp", 8'(stage_ramping), 8'h07);
    cyc(256);
    chk("full", 8'(stage_at_full), 8'h07);
    chk("sw", 8'(speaker_switch_en), 8'h01);
    overtemp = 1'b1;
    cyc(5);
    chk("sw", 8'(speaker_switch_en), 8'h00);
    rd_chk(1'h0, 7'h03, 8'h02);
    overtemp = 1'b0;
    cyc(5);
    chk("sw", 8'(speaker_switch_en), 8'h01);
    spk_overcurrent = 1'b1;
    cyc(5);
    chk("pwr", 8'(pwr), 8'h03);
    rd_chk(1'h1, 7'h20, 8'h01);
    // one re-arm into a live overcurrent, trips again
    wr(1'h1, 7'h20, 8'h80);
    cyc(3);
    chk("pwr", 8'(pwr), 8'h03);
    spk_overcurrent = 1'b0;
    cyc(4);
    rd(1'h1, 7'h20);
    wr(1'h1, 7'h20, 8'h80);
    cyc(3);
    chk("pwr", 8'(pwr), 8'h07);
  endtask : t_speaker

  task automatic t_sw_reset;
    sw_reset = 1'b1;
    @(negedge mclk);
    sw_reset = 1'b0;
    cyc(1);
    chk("pwr", 8'(pwr), 8'h00);
    rd_chk(1'h1, 7'h28, 8'h00);
    rd_chk(1'h1, 7'h1f, 8'h00);
  endtask : t_sw_reset

  // ****************************************************
  // sequence and hang guard
  // ****************************************************
  // reset, then every scenario in turn
  initial
  begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_settings();
    t_hp_short();
    t_speaker();
    t_sw_reset();
    complete_run();
  end

  // cycle ceiling
  always @(posedge mclk)
  begin
    cyc_count++;
    if (cyc_count == 4000)
    begin
      bad_count++;
      complete_run();
    end
  end
endmodule : output_driver_power_protection_tb

bind output_driver_power_protection output_driver_properties chk
(
  .mclk(mclk), .rst(rst), .clk_en(clk_en), .sw_reset(sw_reset), .reg_page(reg_page), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
  .left_short(left_short), .right_short(right_short), .spk_overcurrent(spk_overcurrent), .overtemp(overtemp),
  .left_headphone_out_pwr(left_headphone_out_pwr), .right_headphone_out_pwr(right_headphone_out_pwr),
  .speaker_out_pwr(speaker_out_pwr), .stage_ramping(stage_ramping), .stage_at_full(stage_at_full),
  .speaker_switch_en(speaker_switch_en), .left_gain(left_gain), .left_mute(left_mute), .right_gain(right_gain),
  .right_mute(right_mute), .common_mode_sel(common_mode_sel), .lineout_mode(lineout_mode),
  .left_current_limit(left_current_limit), .right_current_limit(right_current_limit),
  .spk_gain(spk_gain), .spk_mute(spk_mute)
);

`default_nettype wire
